// [rtl/bbre_pkg.sv]
// Package for the block-transfer engine: register map, fields, types.
package bbre_pkg;

  // ****************************************
  // Register byte addresses (I/O space)
  // ****************************************
  localparam logic [15:0] BBRE_LINE_OFFSETS_A   = 16'h83D0;
  localparam logic [15:0] BBRE_PATTERN_PTR_A    = 16'h87D0;
  localparam logic [15:0] BBRE_BACKGROUND_A     = 16'h8BD0;
  localparam logic [15:0] BBRE_FOREGROUND_A     = 16'h8FD0;
  localparam logic [15:0] BBRE_BLIT_CONTROL_A   = 16'h93D0;
  localparam logic [15:0] BBRE_SOURCE_ADDR_A    = 16'h97D0;
  localparam logic [15:0] BBRE_DEST_ADDR_A      = 16'h9BD0;
  localparam logic [15:0] BBRE_BLOCK_SIZE_CMD_A = 16'h9FD0;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int BBRE_ADDR_W     = 21;
  localparam int BBRE_CNT_W      = 12;
  localparam int BBRE_HI_LSB     = 16;  // Upper-half 12-bit fields
  localparam int BBRE_ROP_MSB    = 7;
  localparam int BBRE_INC_Y_BIT  = 8;
  localparam int BBRE_INC_X_BIT  = 9;
  localparam int BBRE_SRC_FG_BIT = 10;
  localparam int BBRE_SRC_MONO   = 11;
  localparam int BBRE_PAT_MONO   = 12;
  localparam int BBRE_BG_TRANSP  = 13;
  localparam int BBRE_SD_LSB     = 14;
  localparam int BBRE_SEED_LSB   = 16;
  localparam int BBRE_SOLID_BIT  = 19;
  localparam int BBRE_BUSY_BIT   = 20;
  localparam int BBRE_FREE_LSB   = 24;
  localparam int BBRE_CTL_W      = 20;  // Writable control bits 19..0

  // Source/destination codes
  localparam logic [1:0] BBRE_SD_SCREEN = 2'h0;
  localparam logic [1:0] BBRE_SD_HOST   = 2'h1;

  // Host queue depth in doublewords
  localparam int         BBRE_Q_DEPTH = 15;
  localparam logic [3:0] BBRE_Q_FULL  = 4'hF;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic                   solid;
    logic [2:0]             seed;
    logic [1:0]             src_dst;
    logic                   bg_transp;
    logic                   pat_mono;
    logic                   src_mono;
    logic                   src_fg;
    logic                   inc_x;
    logic                   inc_y;
    logic [BBRE_ROP_MSB:0]  rop;
  } bbre_ctl_t;

  typedef struct packed {
    logic                   we;
    logic [BBRE_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
  } bbre_mem_req_t;

  typedef enum logic [2:0] {
    BBRE_IDLE = 3'b000,
    BBRE_PAT  = 3'b001,
    BBRE_SRC  = 3'b010,
    BBRE_HOST = 3'b011,
    BBRE_DST  = 3'b100,
    BBRE_WR   = 3'b101
  } bbre_state_t;

endpackage

// [rtl/bbre_engine.sv]
// Block-transfer engine: I/O registers, host queue and byte drawing sequencer.
module bbre_engine (
  input  wire logic                    mclk_in,
  input  wire logic                    rstn_in,
  // I/O register port
  input  wire logic [15:0]             io_addr_in,
  input  wire logic [3:0]              io_be_in,
  input  wire logic                    io_wr_in,
  input  wire logic                    io_rd_in,
  input  wire logic [31:0]             io_wdata_in,
  output logic      [31:0]             io_rdata_out,
  // Host source data stream
  input  wire logic                    host_valid_in,
  input  wire logic [31:0]             host_data_in,
  output logic                         host_ready_out,
  // Pixel depth strap: 0 = 8bpp, 1 = 16bpp
  input  wire logic                    pix16_in,
  // Display memory port
  output logic                         mem_req_out,
  output bbre_pkg::bbre_mem_req_t      mem_cmd_out,
  input  wire logic                    mem_ack_in,
  input  wire logic [7:0]              mem_rdata_in,
  output logic                         busy_out
);
  import bbre_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [BBRE_CNT_W-1:0]  src_off_r, dst_off_r;
  logic [BBRE_ADDR_W-1:0] pat_ptr_r, src_addr_r, dst_addr_r;
  logic [15:0]            bg_r, fg_r;
  bbre_ctl_t              ctl_r;
  logic [BBRE_CNT_W-1:0]  bpl_r, lines_r;
  logic                   start_r;

  logic [31:0] wmask;
  logic [15:0] hit_sel;
  logic        sel_off, sel_pat, sel_bg, sel_fg, sel_ctl, sel_src, sel_dst, sel_cmd;
  logic [3:0]  q_cnt_r;
  logic [3:0]  q_free;
  bbre_state_t state_r, state_nxt;

  // Byte lanes widened to a bit mask; word or doubleword accesses both work
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{io_be_in[i]}};
    end
  end

  // Decode on the doubleword address; the two low address bits are lanes
  assign hit_sel = {io_addr_in[15:2], 2'h0};
  assign sel_off = (hit_sel == BBRE_LINE_OFFSETS_A);
  assign sel_pat = (hit_sel == BBRE_PATTERN_PTR_A);
  assign sel_bg  = (hit_sel == BBRE_BACKGROUND_A);
  assign sel_fg  = (hit_sel == BBRE_FOREGROUND_A);
  assign sel_ctl = (hit_sel == BBRE_BLIT_CONTROL_A);
  assign sel_src = (hit_sel == BBRE_SOURCE_ADDR_A);
  assign sel_dst = (hit_sel == BBRE_DEST_ADDR_A);
  assign sel_cmd = (hit_sel == BBRE_BLOCK_SIZE_CMD_A);

  // ****************************************
  // Register writes
  // ****************************************
  // Writes merge under byte enables; reserved bits are not stored
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_off_r  <= '0;
      dst_off_r  <= '0;
      pat_ptr_r  <= '0;
      bg_r       <= '0;
      fg_r       <= '0;
      ctl_r      <= '0;
      src_addr_r <= '0;
      dst_addr_r <= '0;
      bpl_r      <= '0;
      lines_r    <= '0;
    end else if (io_wr_in) begin
      if (sel_off) begin
        src_off_r <= (io_wdata_in[BBRE_CNT_W-1:0] & wmask[BBRE_CNT_W-1:0])
                   | (src_off_r & ~wmask[BBRE_CNT_W-1:0]);
        dst_off_r <= (io_wdata_in[BBRE_HI_LSB +: BBRE_CNT_W] & wmask[BBRE_HI_LSB +: BBRE_CNT_W])
                   | (dst_off_r & ~wmask[BBRE_HI_LSB +: BBRE_CNT_W]);
      end
      if (sel_pat) begin  // All 21 address bits stored and read back
        pat_ptr_r <= (io_wdata_in[BBRE_ADDR_W-1:0] & wmask[BBRE_ADDR_W-1:0])
                   | (pat_ptr_r & ~wmask[BBRE_ADDR_W-1:0]);
      end
      if (sel_bg) begin
        bg_r <= (io_wdata_in[15:0] & wmask[15:0]) | (bg_r & ~wmask[15:0]);
      end
      if (sel_fg) begin
        fg_r <= (io_wdata_in[15:0] & wmask[15:0]) | (fg_r & ~wmask[15:0]);
      end
      if (sel_ctl) begin
        ctl_r <= (io_wdata_in[BBRE_CTL_W-1:0] & wmask[BBRE_CTL_W-1:0])
               | (ctl_r & ~wmask[BBRE_CTL_W-1:0]);
      end
      if (sel_src) begin  // Byte-granular 21-bit start
        src_addr_r <= (io_wdata_in[BBRE_ADDR_W-1:0] & wmask[BBRE_ADDR_W-1:0])
                    | (src_addr_r & ~wmask[BBRE_ADDR_W-1:0]);
      end
      if (sel_dst) begin
        dst_addr_r <= (io_wdata_in[BBRE_ADDR_W-1:0] & wmask[BBRE_ADDR_W-1:0])
                    | (dst_addr_r & ~wmask[BBRE_ADDR_W-1:0]);
      end
      if (sel_cmd) begin  // Bytes per line low, lines high
        bpl_r   <= (io_wdata_in[BBRE_CNT_W-1:0] & wmask[BBRE_CNT_W-1:0])
                 | (bpl_r & ~wmask[BBRE_CNT_W-1:0]);
        lines_r <= (io_wdata_in[BBRE_HI_LSB +: BBRE_CNT_W] & wmask[BBRE_HI_LSB +: BBRE_CNT_W])
                 | (lines_r & ~wmask[BBRE_HI_LSB +: BBRE_CNT_W]);
      end
    end
  end

  // Command write launches the transfer one cycle later
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_r <= 1'b0;
    end else begin
      start_r <= io_wr_in && sel_cmd;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data registered; unmapped addresses answer zero
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_rdata_out <= '0;
    end else if (io_rd_in) begin
      io_rdata_out <= '0;
      if (sel_off) begin
        io_rdata_out <= {4'h0, dst_off_r, 4'h0, src_off_r};
      end else if (sel_pat) begin
        io_rdata_out <= {11'h000, pat_ptr_r};
      end else if (sel_bg) begin
        io_rdata_out <= {bg_r, bg_r};  // Upper half mirrors
      end else if (sel_fg) begin
        io_rdata_out <= {fg_r, fg_r};
      end else if (sel_ctl) begin  // Busy and queue space
        io_rdata_out <= {4'h0, q_free, 3'h0, (state_r != BBRE_IDLE), ctl_r};
      end else if (sel_src) begin
        io_rdata_out <= {11'h000, src_addr_r};
      end else if (sel_dst) begin
        io_rdata_out <= {11'h000, dst_addr_r};
      end else if (sel_cmd) begin
        io_rdata_out <= {4'h0, lines_r, 4'h0, bpl_r};
      end
    end
  end

  // ****************************************
  // Host data queue
  // ****************************************
  logic [31:0] q_mem_r [BBRE_Q_DEPTH];
  logic [3:0]  q_rd_r, q_wr_r;
  logic        q_push, q_pop;

  // Ready drops at full so the host is really held off
  assign host_ready_out = (q_cnt_r != BBRE_Q_FULL);
  assign q_push         = host_valid_in && host_ready_out;
  assign q_free         = BBRE_Q_FULL - q_cnt_r;  // 0 full .. 15 free

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_rd_r  <= '0;
      q_wr_r  <= '0;
      q_cnt_r <= '0;
    end else begin
      if (q_push) begin
        q_wr_r <= (q_wr_r == BBRE_Q_FULL - 4'h1) ? 4'h0 : q_wr_r + 4'h1;
      end
      if (q_pop) begin
        q_rd_r <= (q_rd_r == BBRE_Q_FULL - 4'h1) ? 4'h0 : q_rd_r + 4'h1;
      end
      q_cnt_r <= q_cnt_r + {3'h0, q_push} - {3'h0, q_pop};
    end
  end

  // Queue storage, one slot per entry
  generate
    for (genvar g = 0; g < BBRE_Q_DEPTH; g++) begin : g_q
      always_ff @(posedge mclk_in) begin
        if (q_push && q_wr_r == 4'(g)) begin
          q_mem_r[g] <= host_data_in;
        end
      end
    end
  endgenerate

  // ****************************************
  // Drawing sequencer
  // ****************************************
  bbre_ctl_t              job_r;     // Control latched at start
  logic [BBRE_ADDR_W-1:0] sline_r, dline_r, scur_r, dcur_r;
  logic [BBRE_CNT_W-1:0]  col_r, line_r;
  logic [2:0]             row_r, mbit_r;
  logic [1:0]             hb_r;
  logic [31:0]            hword_r;
  logic [7:0]             pat_r, src_r, wdata_r;
  logic                   need_src, host_src, src_fetch, step;
  logic                   mono_bit, pat_bit, skip;
  logic [7:0]             fg_b, bg_b, p_op, s_op, rop_out;
  logic [BBRE_ADDR_W-1:0] pat_addr;
  bbre_state_t            after_pat;

  // Source memory or host only when not replaced by foreground
  assign need_src  = !job_r.src_fg;
  assign host_src  = (job_r.src_dst == BBRE_SD_HOST);
  // Mono source bytes serve eight destination bytes
  assign src_fetch = need_src && (!job_r.src_mono || mbit_r == 3'h0);
  assign after_pat = !src_fetch ? BBRE_DST : (host_src ? BBRE_HOST : BBRE_SRC);

  // Colour byte for this lane; odd addresses take the high byte of the colour register
  assign fg_b = dcur_r[0] ? fg_r[15:8] : fg_r[7:0];
  assign bg_b = dcur_r[0] ? bg_r[15:8] : bg_r[7:0];

  // Pattern address: low alignment bits forced to zero
  always_comb begin
    if (job_r.pat_mono) begin
      pat_addr = {pat_ptr_r[BBRE_ADDR_W-1:3], row_r};
    end else if (pix16_in) begin
      pat_addr = {pat_ptr_r[BBRE_ADDR_W-1:7], row_r, dcur_r[3:0]};
    end else begin
      pat_addr = {pat_ptr_r[BBRE_ADDR_W-1:6], row_r, dcur_r[2:0]};
    end
  end

  // Mono bits are taken most significant first
  assign mono_bit = src_r[3'h7 - mbit_r];
  assign pat_bit  = pat_r[3'h7 - dcur_r[2:0]];

  // Operand build: brush, mono pattern or colour pattern
  always_comb begin
    if (job_r.solid) begin
      p_op = fg_b;
    end else if (job_r.pat_mono) begin
      p_op = pat_bit ? fg_b : bg_b;
    end else begin
      p_op = pat_r;
    end
    if (job_r.src_fg) begin
      s_op = fg_b;
    end else if (job_r.src_mono) begin
      s_op = mono_bit ? fg_b : bg_b;  // Set bits fg, clear bits bg
    end else begin
      s_op = src_r;
    end
  end

  // Transparent background leaves zero-bit pixels untouched
  assign skip = job_r.bg_transp
              && ((job_r.src_mono && need_src && !mono_bit)
              ||  (job_r.pat_mono && !job_r.solid && !pat_bit));

  // Per-bit ternary lookup: index is pattern, source, destination
  generate
    for (genvar b = 0; b < 8; b++) begin : g_rop
      assign rop_out[b] = job_r.rop[{p_op[b], s_op[b], mem_rdata_in[b]}];
    end
  endgenerate

  // A pixel completes on its write, or on a skipped write
  assign step = mem_ack_in && ((state_r == BBRE_WR) || (state_r == BBRE_DST && skip));

  // Next state
  always_comb begin
    state_nxt = state_r;
    q_pop     = 1'b0;
    unique case (state_r)
      BBRE_IDLE: begin
        if (start_r && bpl_r != '0 && lines_r != '0) begin
          state_nxt = ctl_r.solid ? BBRE_SRC : BBRE_PAT;
        end
      end
      BBRE_PAT: begin
        if (mem_ack_in) begin
          state_nxt = after_pat;
        end
      end
      BBRE_SRC: begin
        if (!src_fetch) begin
          state_nxt = BBRE_DST;  // Entered from idle or after a completed byte with a brush
        end else if (host_src) begin
          state_nxt = BBRE_HOST;
        end else if (mem_ack_in) begin
          state_nxt = BBRE_DST;
        end
      end
      BBRE_HOST: begin
        // A new doubleword is popped only when the held one is spent
        if (hb_r != 2'h0) begin
          state_nxt = BBRE_DST;
        end else if (q_cnt_r != 4'h0) begin
          q_pop     = 1'b1;
          state_nxt = BBRE_DST;
        end
      end
      BBRE_DST: begin
        if (mem_ack_in) begin
          state_nxt = BBRE_WR;
        end
      end
      BBRE_WR: begin
        if (mem_ack_in) begin
          state_nxt = BBRE_PAT;
        end
      end
      default: begin
        state_nxt = BBRE_IDLE;
      end
    endcase
    if (step) begin  // Busy holds until last byte of last line
      if (col_r == 12'h001 && line_r == 12'h001) begin
        state_nxt = BBRE_IDLE;
      end else begin
        state_nxt = job_r.solid ? BBRE_SRC : BBRE_PAT;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= BBRE_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Operand capture and write data
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pat_r   <= '0;
      src_r   <= '0;
      wdata_r <= '0;
      hword_r <= '0;
      hb_r    <= '0;
    end else begin
      if (state_r == BBRE_IDLE) begin
        hb_r <= '0;
      end
      if (state_r == BBRE_PAT && mem_ack_in) begin
        pat_r <= mem_rdata_in;
      end
      if (state_r == BBRE_SRC && src_fetch && !host_src && mem_ack_in) begin
        src_r <= mem_rdata_in;
      end
      if (state_r == BBRE_HOST) begin  // Host bytes little-endian
        if (hb_r != 2'h0) begin
          src_r <= hword_r[{hb_r, 3'h0} +: 8];
          hb_r  <= hb_r + 2'h1;
        end else if (q_pop) begin
          hword_r <= q_mem_r[q_rd_r];
          src_r   <= q_mem_r[q_rd_r][7:0];
          hb_r    <= 2'h1;
        end
      end
      if (state_r == BBRE_DST && mem_ack_in) begin
        wdata_r <= rop_out;
      end
    end
  end

  // Address walk, counters and pattern row
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      job_r   <= '0;
      sline_r <= '0;
      dline_r <= '0;
      scur_r  <= '0;
      dcur_r  <= '0;
      col_r   <= '0;
      line_r  <= '0;
      row_r   <= '0;
      mbit_r  <= '0;
    end else if (state_r == BBRE_IDLE && start_r) begin
      job_r   <= ctl_r;
      sline_r <= src_addr_r;
      dline_r <= dst_addr_r;
      scur_r  <= src_addr_r;
      dcur_r  <= dst_addr_r;
      col_r   <= bpl_r;
      line_r  <= lines_r;
      row_r   <= ctl_r.seed;  // First line uses the seed row
      mbit_r  <= '0;
    end else if (step) begin
      if (col_r == 12'h001) begin
        // New line: step by the offsets in the vertical direction
        col_r  <= bpl_r;
        line_r <= line_r - 12'h001;
        mbit_r <= '0;
        if (job_r.inc_y) begin
          sline_r <= sline_r + BBRE_ADDR_W'(src_off_r);
          dline_r <= dline_r + BBRE_ADDR_W'(dst_off_r);
          scur_r  <= sline_r + BBRE_ADDR_W'(src_off_r);
          dcur_r  <= dline_r + BBRE_ADDR_W'(dst_off_r);
          row_r   <= row_r + 3'h1;
        end else begin
          sline_r <= sline_r - BBRE_ADDR_W'(src_off_r);
          dline_r <= dline_r - BBRE_ADDR_W'(dst_off_r);
          scur_r  <= sline_r - BBRE_ADDR_W'(src_off_r);
          dcur_r  <= dline_r - BBRE_ADDR_W'(dst_off_r);
          row_r   <= row_r - 3'h1;
        end
      end else begin
        col_r  <= col_r - 12'h001;
        mbit_r <= mbit_r + 3'h1;
        // Horizontal walk; mono source advances once per eight bytes
        if (job_r.inc_x) begin
          dcur_r <= dcur_r + 21'h000001;
          if (!job_r.src_mono || mbit_r == 3'h7) begin
            scur_r <= scur_r + 21'h000001;
          end
        end else begin
          dcur_r <= dcur_r - 21'h000001;
          if (!job_r.src_mono || mbit_r == 3'h7) begin
            scur_r <= scur_r - 21'h000001;
          end
        end
      end
    end
  end

  // ****************************************
  // Memory port and status
  // ****************************************
  // Every access targets display memory; writes only to destination
  always_comb begin
    mem_req_out       = 1'b0;
    mem_cmd_out.we    = 1'b0;
    mem_cmd_out.addr  = dcur_r;
    mem_cmd_out.wdata = wdata_r;
    unique case (state_r)
      BBRE_PAT: begin
        mem_req_out      = 1'b1;
        mem_cmd_out.addr = pat_addr;
      end
      BBRE_SRC: begin
        mem_req_out      = src_fetch && !host_src;
        mem_cmd_out.addr = scur_r;
      end
      BBRE_DST: begin
        mem_req_out = 1'b1;
      end
      BBRE_WR: begin
        mem_req_out    = 1'b1;
        mem_cmd_out.we = 1'b1;
      end
      BBRE_IDLE, BBRE_HOST: begin
        mem_req_out = 1'b0;
      end
      default: begin
        mem_req_out = 1'b0;
      end
    endcase
  end

  assign busy_out = (state_r != BBRE_IDLE);

endmodule

// [sim/bbre_engine_properties.sv]
// Port-level checks for the block-transfer engine.
module bbre_engine_properties (
  input wire logic                    mclk_in,
  input wire logic                    rstn_in,
  input wire logic [15:0]             io_addr_in,
  input wire logic [3:0]              io_be_in,
  input wire logic                    io_wr_in,
  input wire logic                    io_rd_in,
  input wire logic [31:0]             io_wdata_in,
  input wire logic [31:0]             io_rdata_out,
  input wire logic                    host_ready_out,
  input wire logic                    mem_req_out,
  input wire bbre_pkg::bbre_mem_req_t mem_cmd_out,
  input wire logic                    mem_ack_in,
  input wire logic                    busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import bbre_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // Decoded strobes; low address bits only pick lanes
  logic rd_fg, rd_ptr, rd_ctl, go_w;
  assign rd_fg  = io_rd_in && io_addr_in[15:2] == BBRE_FOREGROUND_A[15:2];
  assign rd_ptr = io_rd_in && io_addr_in[15:2] == BBRE_PATTERN_PTR_A[15:2];
  assign rd_ctl = io_rd_in && io_addr_in[15:2] == BBRE_BLIT_CONTROL_A[15:2];
  assign go_w   = io_wr_in && io_be_in == 4'hF && !busy_out
                  && io_addr_in[15:2] == BBRE_BLOCK_SIZE_CMD_A[15:2];
  req_hold_a: assert property (mem_req_out && !mem_ack_in
    |=> mem_req_out && $stable(mem_cmd_out)) else $error("request changed before ack");
  start_busy_a: assert property (go_w && io_wdata_in[11:0] != 12'h0
    && io_wdata_in[27:16] != 12'h0 |-> ##2 busy_out) else $error("start missed");
  zero_idle_a: assert property (go_w && io_wdata_in[11:0] == 12'h0
    |=> !busy_out [*2]) else $error("empty size started");
  req_busy_a: assert property (mem_req_out |-> busy_out) else $error("request idle");
  fg_mirror_a: assert property (rd_fg
    |=> io_rdata_out[31:16] == io_rdata_out[15:0]) else $error("colour not mirrored");
  ptr_width_a: assert property (rd_ptr
    |=> io_rdata_out[31:21] == 11'h0) else $error("pointer upper bits set");
  busy_bit_a: assert property (rd_ctl
    |=> io_rdata_out[BBRE_BUSY_BIT] == $past(busy_out)) else $error("busy bit wrong");
  free_cnt_a: assert property (rd_ctl
    |=> (io_rdata_out[27:24] != 4'h0) == $past(host_ready_out)) else $error("free count");
  cover property (go_w);
  cover property (mem_req_out && mem_cmd_out.we && mem_ack_in);
  cover property ($fell(busy_out));
endmodule
bind bbre_engine bbre_engine_properties u_props (.*);

// [sim/bbre_mem_model.sv]
// Display memory model answering the engine's byte requests.
module bbre_mem_model (
  input  wire logic                    mclk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    mem_req_in,
  input  wire bbre_pkg::bbre_mem_req_t mem_cmd_in,
  output logic                         mem_ack_out,
  output logic [7:0]                   mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import bbre_pkg::*;
  logic [7:0] mem [0:511];  // Address wraps at 512 bytes
  logic       slow_r;
  // Free-running toggle gives both prompt and late answers
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_ack_out <= 1'b0;
      slow_r      <= 1'b0;
    end else begin
      slow_r      <= !slow_r;
      mem_ack_out <= mem_req_in && !mem_ack_out && slow_r;
      if (mem_req_in && !mem_ack_out && slow_r && mem_cmd_in.we) begin
        mem[mem_cmd_in.addr[8:0]] <= mem_cmd_in.wdata;
      end
    end
  end
  // Off the ack the inverse shows, so a stale sample never matches
  assign mem_rdata_out = mem_ack_out ? mem[mem_cmd_in.addr[8:0]] : ~mem[mem_cmd_in.addr[8:0]];
endmodule

// [sim/bitblt_register_engine_bench.sv]
// Self-checking bench for the block-transfer engine.
module bitblt_register_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import bbre_pkg::*;
  logic          mclk_in = 1'b0;
  logic          rstn_in = 1'b0;
  logic          io_wr_in = 1'b0;
  logic          io_rd_in = 1'b0;
  logic [15:0]   io_addr_in = 16'h0;
  logic [31:0]   io_wdata_in = 32'h0;
  logic [31:0]   io_rdata_out;
  logic          host_ready_out, mem_req_out, mem_ack_in, busy_out;
  logic [7:0]    mem_rdata_in;
  bbre_mem_req_t mem_cmd_out;
  int            bad_count = 0;
  int            n_tests = 0;
  logic [3:0]    io_be_in = 4'hF;
  logic          host_valid_in = 1'b0;
  logic [31:0]   host_data_in = 32'h4433_2211;  // Distinct bytes show lane order
  // Colour patterns are not drawn here, so the depth strap stays at 8bpp
  bbre_engine u_dut (.*, .pix16_in(1'b0));
  bbre_mem_model u_mem (.mclk_in, .rstn_in, .mem_req_in(mem_req_out), .mem_cmd_in(mem_cmd_out),
                        .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
  always #10 mclk_in = ~mclk_in;
  task automatic chk(string w, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask
  // One-cycle strobes; a gap cycle keeps each pulse separate
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge mclk_in);
    io_addr_in  <= a;
    io_wdata_in <= d;
    io_wr_in    <= 1'b1;
    @(posedge mclk_in);
    io_wr_in    <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_rd_in   <= 1'b1;
    @(posedge mclk_in);
    io_rd_in   <= 1'b0;
    #1 d = io_rdata_out;
  endtask
  function automatic logic [7:0] pre(int i);
    return i[7:0] ^ 8'h5A;
  endfunction
  // Spare edge before the status read; busy is already set one edge after the command write
  task automatic blt(logic [31:0] ctl, logic [31:0] src, logic [31:0] dst, logic [31:0] sz,
                     logic [3:0] fr = 4'hF);
    logic [31:0] d;
    wr(BBRE_BLIT_CONTROL_A, ctl);
    wr(BBRE_SOURCE_ADDR_A, src);
    wr(BBRE_DEST_ADDR_A, dst);
    wr(BBRE_BLOCK_SIZE_CMD_A, sz);
    @(posedge mclk_in);
    rd(BBRE_BLIT_CONTROL_A, d);
    chk("ctl busy", d, {4'h0, fr, 4'h1, ctl[19:0]});
    for (int n = 0; n < 4000 && busy_out !== 1'b0; n++) @(posedge mclk_in);
    chk("busy_out", 32'(busy_out), 32'h0);
  endtask
  task automatic t_regs();
    logic [15:0] a [5] = '{BBRE_FOREGROUND_A, BBRE_BACKGROUND_A, BBRE_PATTERN_PTR_A,
                           BBRE_LINE_OFFSETS_A, 16'hA3D0};
    logic [31:0] e [5] = '{32'h5A3C_5A3C, 32'h5A3C_5A3C, 32'h001F_FFFF, 32'h0FFF_0FFF, 32'h0};
    logic [31:0] d;
    foreach (a[i]) begin
      wr(a[i], i < 2 ? 32'hABCD_5A3C : 32'hFFFF_FFFF);
      rd(a[i], d);
      chk("readback", d, e[i]);
    end
    // Word access to the upper lanes leaves the source offset alone
    io_be_in <= 4'hC;
    wr(BBRE_LINE_OFFSETS_A, 32'h0123_0456);
    io_be_in <= 4'hF;
    rd(BBRE_LINE_OFFSETS_A, d);
    chk("word write", d, 32'h0123_0FFF);
    wr(BBRE_BLOCK_SIZE_CMD_A, 32'h0005_0000);
    rd(BBRE_BLIT_CONTROL_A, d);
    chk("empty size", d, 32'h0F00_0000);
  endtask
  // Solid fill with source OR destination
  task automatic t_fill();
    wr(BBRE_FOREGROUND_A, 32'h0000_7E7E);
    blt(32'h0008_07EE, 32'h0, 32'h10, 32'h0001_0003);
    for (int k = 0; k < 4; k++) begin
      chk("fill", 32'(u_mem.mem[16 + k]), 32'(k < 3 ? 8'h7E | pre(16 + k) : pre(19)));
    end
  endtask
  // Two-line copies, forward then reversed; third byte must stay
  task automatic t_copy();
    wr(BBRE_LINE_OFFSETS_A, 32'h0040_0040);
    blt(32'h0008_03CC, 32'h20, 32'h100, 32'h0002_0002);
    blt(32'h0008_00CC, 32'h61, 32'h1C1, 32'h0002_0002);
    for (int k = 0; k < 3; k++) begin
      chk("fwd 1", 32'(u_mem.mem[256 + k]), 32'(pre(k < 2 ? 32 + k : 258)));
      chk("fwd 2", 32'(u_mem.mem[320 + k]), 32'(pre(k < 2 ? 96 + k : 322)));
      chk("rev 1", 32'(u_mem.mem[448 + k]), 32'(pre(k < 2 ? 96 + k : 450)));
      chk("rev 2", 32'(u_mem.mem[384 + k]), 32'(pre(k < 2 ? 32 + k : 386)));
    end
  endtask
  // Mono expansion, opaque then transparent
  task automatic t_mono();
    logic [7:0] sb = pre(48);
    wr(BBRE_FOREGROUND_A, 32'h0000_5555);
    wr(BBRE_BACKGROUND_A, 32'h0000_2222);
    blt(32'h0008_0BCC, 32'h30, 32'h1E0, 32'h0001_0008);
    blt(32'h0008_2BCC, 32'h30, 32'h1F0, 32'h0001_0008);
    for (int k = 0; k < 8; k++) begin
      chk("opaque", 32'(u_mem.mem[480 + k]), sb[7 - k] ? 32'h55 : 32'h22);
      chk("transp", 32'(u_mem.mem[496 + k]), sb[7 - k] ? 32'h55 : 32'(pre(496 + k)));
    end
  endtask
  // Mono pattern, two lines: seed row first, next row on the line below
  task automatic t_pat();
    logic [7:0] r1 = pre(201);
    logic [7:0] r2 = pre(202);
    wr(BBRE_PATTERN_PTR_A, 32'h0000_00C8);
    blt(32'h0001_13F0, 32'h0, 32'h0A0, 32'h0002_0008);
    for (int k = 0; k < 8; k++) begin
      chk("pat row 1", 32'(u_mem.mem[160 + k]), r1[7 - k] ? 32'h55 : 32'h22);
      chk("pat row 2", 32'(u_mem.mem[224 + k]), r2[7 - k] ? 32'h55 : 32'h22);
    end
  endtask
  // Host-fed copy: one queued doubleword, low byte drawn first
  task automatic t_host();
    @(posedge mclk_in);
    host_valid_in <= 1'b1;
    @(posedge mclk_in);
    host_valid_in <= 1'b0;
    blt(32'h0008_43CC, 32'h0, 32'h0C0, 32'h0001_0004, 4'hE);
    for (int k = 0; k < 4; k++) begin
      chk("host", 32'(u_mem.mem[192 + k]), 32'(host_data_in[8*k +: 8]));
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 512; i++) u_mem.mem[i] = pre(i);
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_fill();
    t_copy();
    t_mono();
    t_pat();
    t_host();
    finish_test();
  end
  // Watchdog well past the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    finish_test();
  end
endmodule
